// ---- verilog/rbp_pkg.sv ----
// Shared constants for the replay buffer port
`default_nettype none

package rbp_pkg;
    // ==========================================
    // Buffer geometry
    localparam int ENTRY_W = 644;
    localparam int BANK_DEPTH = 512;
    localparam int NUM_BANKS = 4;
    localparam int SEL_W = 2;
    localparam int ROW_W = 9;
    localparam int PTR_W = 11;
    localparam int SPAN_W = 12;
    localparam int SEQ_W = 8;
    localparam int TIMER_W = 16;
    // ==========================================
    // Sizing figures
    localparam int WORDS_PER_ENTRY = 8;
    localparam int BURST_WORDS_MAX = 33;
    localparam int MIN_SEQS = 5;
    localparam int MAX_MULT_EXP = 5;
    localparam int MAX_WR_STAGES = 2;
    // ==========================================
    // Read latency: RAM read plus output register, then the mux flop
    localparam int RAM_LAT = 2;
    localparam int RD_LAT = 3;
    // ==========================================
    // Register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DEPTH = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_TIMER = 4'hC;
    // ==========================================
    // Field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_BANK_LSB = 1;
    localparam int CTRL_MULT_LSB = 3;
    localparam int CTRL_REREQ_BIT = 6;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LOW_BIT = 1;
    localparam int STAT_FILL_LSB = 4;
    // ==========================================
    // Reset values
    localparam logic [SPAN_W-1:0] DEPTH_RST = 12'h200;
    localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0400;
endpackage : rbp_pkg

`default_nettype wire

// ---- verilog/rbp_pipe.sv ----
// Reset delay line of N register stages, N may be zero
`default_nettype none

module rbp_pipe #(
    parameter int W = 1,
    parameter int N = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // ==========================================
    // Stages
    if (N < 0 || W < 1) begin : g_bad
        $error("rbp_pipe: unsupported W or N");
    end else if (N == 0) begin : g_thru
        assign q_o = d_i;
    end else begin : g_reg
        typedef struct packed {
            logic [N-1:0][W-1:0] stg;
        } rbp_pipe_st_t;
        rbp_pipe_st_t st;
        rbp_pipe_st_t next_st;
        // Shift one stage per clock
        always_comb begin
            next_st = st;
            next_st.stg[0] = d_i;
            for (int i = 1; i < N; i++) begin
                next_st.stg[i] = st.stg[i-1];
            end
        end
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                st <= '0;
            end else begin
                st <= next_st;
            end
        end
        assign q_o = st.stg[N-1];
    end
endmodule : rbp_pipe

`default_nettype wire

// ---- verilog/rbp_disc_chk.sv ----
// Receive-side sequence discontinuity detector and re-request timer
`default_nettype none

module rbp_disc_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ctl_valid_i,
    input wire logic is_burst_i,
    input wire logic crc_err_i,
    input wire logic [rbp_pkg::SEQ_W-1:0] seq_i,
    input wire logic req_sent_i,
    input wire logic rereq_en_i,
    input wire logic [rbp_pkg::TIMER_W-1:0] timer_i,
    output logic disc_o,
    output logic rereq_o
);
    import rbp_pkg::*;

    typedef struct packed {
        logic have_last;
        logic [SEQ_W-1:0] last_seq;
        logic err_gap;
        logic waiting;
        logic [TIMER_W-1:0] cnt;
        logic disc;
        logic rereq;
    } rbp_chk_st_t;

    rbp_chk_st_t st;
    rbp_chk_st_t next_st;

    // ==========================================
    // Compare burst words; idles only matter when they fail CRC
    always_comb begin
        next_st = st;
        next_st.disc = 1'b0;
        next_st.rereq = 1'b0;
        if (ctl_valid_i) begin
            if (crc_err_i) begin
                next_st.err_gap = 1'b1;
            end else if (is_burst_i) begin
                if (st.have_last && !st.err_gap && seq_i != st.last_seq
                    && seq_i != SEQ_W'(st.last_seq + 1'b1)) begin
                    next_st.disc = 1'b1;
                end
                next_st.have_last = 1'b1;
                next_st.last_seq = seq_i;
                next_st.err_gap = 1'b0;
            end
        end
        // A zero timer disables re-requests rather than firing at once
        if (req_sent_i) begin
            next_st.waiting = 1'b1;
            next_st.cnt = '0;
        end else if (st.waiting) begin
            if (next_st.disc) begin
                next_st.waiting = 1'b0;
            end else if (timer_i != '0 && st.cnt >= timer_i - 1'b1) begin
                next_st.rereq = rereq_en_i;
                next_st.waiting = rereq_en_i;
                next_st.cnt = '0;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign disc_o = st.disc;
    assign rereq_o = st.rereq;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_DISC_CLEAN: assert property (
        disc_o |-> $past(ctl_valid_i && is_burst_i && !crc_err_i))
        else $error("discontinuity without a clean burst word");
    AST_DISC_ERR: assert property (
        (ctl_valid_i && crc_err_i) ##1 (ctl_valid_i && is_burst_i) |=> !disc_o)
        else $error("discontinuity accepted across a CRC error");
    AST_REREQ: assert property (
        rereq_o |-> $past(rereq_en_i) && !disc_o)
        else $error("re-request while disabled");
    CVR_DISC: cover property (disc_o);
endmodule : rbp_disc_chk

`default_nettype wire

// ---- verilog/rbp_top.sv ----
// Replay buffer port: bank RAM ports, replay sequencing, config registers
`default_nettype none
// ==========================================
// Overview of operation
// - Each replay starts with a discontinuity marker; receiver takes it as replay start.
// - Receiver flags discontinuity on unexpected sequence change between clean burst words.
// - Any number of clean idle words between the two bursts is allowed.
// - A CRC error anywhere between the two bursts voids the pair.
// - Without a found discontinuity, re-request replay when enabled.
// - With replay on, outgoing data is written via word, index and bank strobes.
// - Buffered data is read via shared index, bank read strobes, read word input.
// - A 2-bit setting selects how many banks are used.
// - Banks share write word and index; each has its own write strobe.
// - Banks share read index; own read strobes; select N passes bank N.
// - Up to two pipeline stages on the write path are tolerated.
// - A depth setting limits the number of entries used, eight words each.
// - Multiplier is 1, 2, 4, 8, 16 or 32 bursts per sequence number.

module rbp_top #(
    parameter int WR_STAGES = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic in_valid_i,
    input wire logic in_burst_start_i,
    input wire logic [rbp_pkg::ENTRY_W-1:0] in_data_i,
    output logic in_ready_o,
    output logic [rbp_pkg::SEQ_W-1:0] tx_seq_o,
    input wire logic replay_req_i,
    input wire logic replay_req_valid_i,
    output logic replay_busy_o,
    output logic out_valid_o,
    output logic out_disc_o,
    output logic [rbp_pkg::ENTRY_W-1:0] out_data_o,
    output logic [rbp_pkg::ENTRY_W-1:0] buf_wr_word_o,
    output logic [rbp_pkg::ROW_W-1:0] buf_wr_index_o,
    output logic [rbp_pkg::NUM_BANKS-1:0] bank_wr_strobe_o,
    input wire logic [rbp_pkg::ENTRY_W-1:0] buf_rd_word_i,
    output logic [rbp_pkg::ROW_W-1:0] buf_rd_index_o,
    output logic [rbp_pkg::NUM_BANKS-1:0] bank_rd_strobe_o,
    output logic [rbp_pkg::SEL_W-1:0] bank_mux_select_o,
    input wire logic rx_ctl_valid_i,
    input wire logic rx_is_burst_i,
    input wire logic rx_crc_err_i,
    input wire logic [rbp_pkg::SEQ_W-1:0] rx_seq_i,
    input wire logic rx_req_sent_i,
    output logic rx_disc_o,
    output logic rx_rereq_o
);
    import rbp_pkg::*;

    if (WR_STAGES < 0 || WR_STAGES > MAX_WR_STAGES) begin : g_bad
        $error("rbp_top: WR_STAGES out of range");
    end

    typedef enum logic [1:0] {MODE_FILL, MODE_SETTLE, MODE_REPLAY} rbp_mode_t;

    typedef struct packed {
        logic tx_replay_on;
        logic [1:0] bank_count_cfg;
        logic [2:0] mult;
        logic rereq_en;
        logic [SPAN_W-1:0] buffer_depth_cfg;
        logic [TIMER_W-1:0] long_timer_cfg;
        logic ack;
        logic [31:0] rdata;
        rbp_mode_t mode;
        logic armed;
        logic [1:0] settle;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [SPAN_W-1:0] fill;
        logic [SPAN_W-1:0] rem;
        logic first;
        logic [SEQ_W-1:0] seq;
        logic [4:0] sub;
        logic [ENTRY_W-1:0] wr_word;
        logic [ROW_W-1:0] wr_row;
        logic [NUM_BANKS-1:0] wr_stb;
        logic [ROW_W-1:0] rd_row;
        logic [NUM_BANKS-1:0] rd_stb;
        logic [SEL_W-1:0] rd_sel;
        logic rd_first;
        logic out_valid;
        logic out_disc;
        logic [ENTRY_W-1:0] out_data;
    } rbp_state_t;

    rbp_state_t st;
    rbp_state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [SPAN_W-1:0] cap;
    logic [SPAN_W-1:0] span;
    logic [SPAN_W-1:0] oldest;
    logic [15:0] mult_val;
    logic [15:0] need_entries;
    logic depth_low;
    logic wr_go;
    logic [1:0] lat_q;

    // ==========================================
    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==========================================
    // Buffer span from bank count and depth setting
    always_comb begin
        cap = SPAN_W'({st.bank_count_cfg, ROW_W'(0)}) + SPAN_W'(BANK_DEPTH);
        // Zero or oversize depth falls back to all enabled banks
        if (st.buffer_depth_cfg == '0 || st.buffer_depth_cfg > cap) begin
            span = cap;
        end else begin
            span = st.buffer_depth_cfg;
        end
        oldest = (SPAN_W'(st.wr_ptr) >= st.fill) ? SPAN_W'(st.wr_ptr) - st.fill
                 : SPAN_W'(st.wr_ptr) + span - st.fill;
        mult_val = 16'h0001 << st.mult;
        need_entries = (mult_val * 16'(BURST_WORDS_MAX * MIN_SEQS)) >> 3;
        depth_low = 16'(span) <= need_entries;
        wr_go = st.mode == MODE_FILL && in_valid_i && st.tx_replay_on;
    end

    // ==========================================
    // Next state: bus slave, write side, replay sequencer
    always_comb begin
        next_st = st;
        next_st.wr_stb = '0;
        next_st.rd_stb = '0;
        next_st.rd_first = 1'b0;
        next_st.out_valid = lat_q[1];
        next_st.out_disc = lat_q[1] & lat_q[0];
        next_st.out_data = buf_rd_word_i;
        // One wait state: answer on the second edge of a request
        next_st.ack = (avs_read_i | avs_write_i) & ~st.ack;
        if (avs_read_i && !st.ack) begin
            unique case (avs_address_i)
                REG_CTRL: next_st.rdata = {25'h0, st.rereq_en, st.mult,
                                           st.bank_count_cfg, st.tx_replay_on};
                REG_DEPTH: next_st.rdata = {20'h0, st.buffer_depth_cfg};
                REG_STAT: next_st.rdata = {16'h0, st.fill, 2'b00, depth_low,
                                           st.mode != MODE_FILL};
                REG_TIMER: next_st.rdata = {16'h0, st.long_timer_cfg};
                default: next_st.rdata = 32'h0;
            endcase
        end
        if (avs_write_i && st.ack) begin
            unique case (avs_address_i)
                REG_CTRL: begin
                    next_st.tx_replay_on = avs_writedata_i[CTRL_ON_BIT];
                    next_st.bank_count_cfg = avs_writedata_i[CTRL_BANK_LSB +: 2];
                    next_st.rereq_en = avs_writedata_i[CTRL_REREQ_BIT];
                    // Illegal multipliers are dropped, the old one stays
                    if (avs_writedata_i[CTRL_MULT_LSB +: 3] <= 3'(MAX_MULT_EXP)) begin
                        next_st.mult = avs_writedata_i[CTRL_MULT_LSB +: 3];
                    end
                end
                REG_DEPTH: next_st.buffer_depth_cfg = avs_writedata_i[SPAN_W-1:0];
                REG_TIMER: next_st.long_timer_cfg = avs_writedata_i[TIMER_W-1:0];
                default: ;
            endcase
        end
        // Store each accepted entry in the circular buffer
        if (wr_go) begin
            next_st.wr_word = in_data_i;
            next_st.wr_row = st.wr_ptr[ROW_W-1:0];
            for (int b = 0; b < NUM_BANKS; b++) begin
                next_st.wr_stb[b] = st.wr_ptr[PTR_W-1:ROW_W] == SEL_W'(b);
            end
            next_st.wr_ptr = (SPAN_W'(st.wr_ptr) >= span - 1'b1) ? '0
                             : st.wr_ptr + 1'b1;
            if (st.fill < span) begin
                next_st.fill = st.fill + 1'b1;
            end
            // Same sequence number for mult bursts in a row
            if (in_burst_start_i) begin
                if (st.sub >= 5'(mult_val - 16'h0001)) begin
                    next_st.sub = '0;
                    next_st.seq = st.seq + 1'b1;
                end else begin
                    next_st.sub = st.sub + 1'b1;
                end
            end
        end
        if (next_st.fill > span) begin
            next_st.fill = span;
        end
        // A new request needs a deasserted request seen in between
        if (replay_req_valid_i && !replay_req_i) begin
            next_st.armed = 1'b1;
        end
        unique case (st.mode)
            MODE_FILL: begin
                if (replay_req_valid_i && replay_req_i && st.armed
                    && st.tx_replay_on && st.fill != '0) begin
                    next_st.armed = 1'b0;
                    next_st.mode = MODE_SETTLE;
                    next_st.settle = '0;
                end
            end
            MODE_SETTLE: begin
                // Let writes still in external stages land before reading
                if (st.settle == 2'(WR_STAGES)) begin
                    next_st.mode = MODE_REPLAY;
                    next_st.first = 1'b1;
                    next_st.rem = st.fill;
                    next_st.rd_ptr = PTR_W'(oldest);
                end else begin
                    next_st.settle = st.settle + 1'b1;
                end
            end
            MODE_REPLAY: begin
                next_st.rd_row = st.rd_ptr[ROW_W-1:0];
                for (int b = 0; b < NUM_BANKS; b++) begin
                    next_st.rd_stb[b] = st.rd_ptr[PTR_W-1:ROW_W] == SEL_W'(b);
                end
                next_st.rd_sel = st.rd_ptr[PTR_W-1:ROW_W];
                next_st.rd_first = st.first;
                next_st.first = 1'b0;
                next_st.rd_ptr = (SPAN_W'(st.rd_ptr) >= span - 1'b1) ? '0
                                 : st.rd_ptr + 1'b1;
                next_st.rem = st.rem - 1'b1;
                if (st.rem == SPAN_W'(1)) begin
                    next_st.mode = MODE_FILL;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.armed <= 1'b1;
            st.buffer_depth_cfg <= DEPTH_RST;
            st.long_timer_cfg <= TIMER_RST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Select follows the RAM latency; valid tracks the whole read path
    rbp_pipe #(.W(SEL_W), .N(RAM_LAT)) u_sel_pipe (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(st.rd_sel),
        .q_o(bank_mux_select_o)
    );
    rbp_pipe #(.W(2), .N(RD_LAT)) u_lat_pipe (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i({|st.rd_stb, st.rd_first}),
        .q_o(lat_q)
    );
    rbp_disc_chk u_disc_chk (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ctl_valid_i(rx_ctl_valid_i),
        .is_burst_i(rx_is_burst_i),
        .crc_err_i(rx_crc_err_i),
        .seq_i(rx_seq_i),
        .req_sent_i(rx_req_sent_i),
        .rereq_en_i(st.rereq_en),
        .timer_i(st.long_timer_cfg),
        .disc_o(rx_disc_o),
        .rereq_o(rx_rereq_o)
    );

    // ==========================================
    // Outputs
    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st.ack;
    assign in_ready_o = st.mode == MODE_FILL;
    assign replay_busy_o = st.mode != MODE_FILL;
    assign tx_seq_o = st.seq;
    assign out_valid_o = st.out_valid;
    assign out_disc_o = st.out_disc;
    assign out_data_o = st.out_data;
    assign buf_wr_word_o = st.wr_word;
    assign buf_wr_index_o = st.wr_row;
    assign bank_wr_strobe_o = st.wr_stb;
    assign buf_rd_index_o = st.rd_row;
    assign bank_rd_strobe_o = st.rd_stb;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    AST_WR_DATA: assert property (
        wr_go |=> (bank_wr_strobe_o != '0) && buf_wr_word_o == $past(in_data_i))
        else $error("write not presented to the banks");
    AST_ONEHOT: assert property (
        $onehot0(bank_wr_strobe_o) && $onehot0(bank_rd_strobe_o))
        else $error("more than one bank strobed");
    AST_SEL_LAT: assert property (
        (|bank_rd_strobe_o) |-> ##2 (bank_mux_select_o == $past(st.rd_sel, 2)))
        else $error("mux select out of step with read");
    AST_RD_DATA: assert property (
        (|bank_rd_strobe_o) |-> ##4 (out_valid_o && out_data_o == $past(buf_rd_word_i)))
        else $error("read word not taken after read latency");
    AST_REPLAY_DISC: assert property (
        $rose(st.mode == MODE_REPLAY) |-> ##5 (out_valid_o && out_disc_o))
        else $error("replay did not open with a discontinuity");
    AST_WRAP: assert property (
        (wr_go && SPAN_W'(st.wr_ptr) >= span - 1'b1) |=> st.wr_ptr == '0)
        else $error("write index failed to wrap");
    AST_MULT: assert property (
        st.mult <= 3'(MAX_MULT_EXP))
        else $error("illegal multiplier held");
    AST_SETTLE: assert property (
        $rose(st.mode == MODE_SETTLE) |-> ##[1:3] $rose(st.mode == MODE_REPLAY))
        else $error("replay did not start after settling");
    AST_BUS: assert property (
        (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
        else $error("bus answer late");
    CVR_REPLAY: cover property ($rose(st.mode == MODE_REPLAY));
    CVR_DISC_OUT: cover property (out_disc_o);
    CVR_WRAP: cover property (wr_go && st.wr_ptr == '0 && st.fill == span);
    CVR_REREQ: cover property (rx_rereq_o);
endmodule : rbp_top

`default_nettype wire

// ---- test/rbp_ram_model.sv ----
// Four-bank replay RAM: write stages, registered outputs, bank mux and output flop
`default_nettype none
module rbp_ram_model (
    input wire logic clk_i,
    input wire logic [rbp_pkg::ENTRY_W-1:0] wr_word_i,
    input wire logic [rbp_pkg::ROW_W-1:0] wr_index_i,
    input wire logic [rbp_pkg::NUM_BANKS-1:0] wr_strobe_i,
    input wire logic [rbp_pkg::ROW_W-1:0] rd_index_i,
    input wire logic [rbp_pkg::NUM_BANKS-1:0] rd_strobe_i,
    input wire logic [rbp_pkg::SEL_W-1:0] mux_select_i,
    output logic [rbp_pkg::ENTRY_W-1:0] rd_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import rbp_pkg::*;
    logic [ENTRY_W-1:0] mem [NUM_BANKS][BANK_DEPTH];
    logic [ENTRY_W-1:0] q1 [NUM_BANKS];
    logic [ENTRY_W-1:0] q2 [NUM_BANKS];
    logic [ENTRY_W+ROW_W+NUM_BANKS-1:0] wp1 = '0;
    logic [ENTRY_W+ROW_W+NUM_BANKS-1:0] wp2 = '0;
    // ==========
    // Two fabric stages on every write signal, the deepest the port must tolerate
    always @(posedge clk_i) begin
        wp1 <= {wr_word_i, wr_index_i, wr_strobe_i};
        wp2 <= wp1;
    end
    // ==========
    // Banks share word and index; output register adds a read cycle
    always @(posedge clk_i) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (wp2[b]) mem[b][wp2[NUM_BANKS+:ROW_W]] <= wp2[NUM_BANKS+ROW_W+:ENTRY_W];
            if (rd_strobe_i[b]) q1[b] <= mem[b][rd_index_i];
            q2[b] <= q1[b];
        end
        rd_word_o <= q2[mux_select_i];
    end
endmodule : rbp_ram_model
`default_nettype wire

// ---- test/tb.sv ----
// Bench: registers, buffer writes with wrap, replay and receive checks
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rbp_pkg::*;
    localparam int SPAN = 515;
    localparam int NIN = 520;
    localparam logic [3:0] RA [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    localparam logic [31:0] RE [5] = '{32'h0, 32'h200, 32'h0, 32'h400, 32'h0};
    logic clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, in_valid_i = 0;
    logic in_burst_start_i = 0, replay_req_i = 0, replay_req_valid_i = 0;
    logic rx_ctl_valid_i = 0, rx_is_burst_i = 0, rx_crc_err_i = 0, rx_req_sent_i = 0;
    logic [3:0] avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
    logic [ENTRY_W-1:0] in_data_i = 0, out_data_o, buf_wr_word_o, buf_rd_word_i;
    logic [7:0] rx_seq_i = 0, tx_seq_o;
    logic avs_waitrequest_o, in_ready_o, replay_busy_o, out_valid_o, out_disc_o;
    logic rx_disc_o, rx_rereq_o;
    logic [ROW_W-1:0] buf_wr_index_o, buf_rd_index_o;
    logic [3:0] bank_wr_strobe_o, bank_rd_strobe_o;
    logic [1:0] bank_mux_select_o;
    logic [656:0] wq[$], oq[$];
    logic [ENTRY_W-1:0] hist [NIN];
    int fail_count = 0, tests_run = 0, nd = 0, nr = 0;
    // ==========
    // Clock, design and buffer with its write stages
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    rbp_top #(.WR_STAGES(2)) dut (.*);
    rbp_ram_model u_ram (.clk_i, .wr_word_i(buf_wr_word_o), .wr_index_i(buf_wr_index_o),
        .wr_strobe_i(bank_wr_strobe_o), .rd_index_i(buf_rd_index_o),
        .rd_strobe_i(bank_rd_strobe_o),
        .mux_select_i(bank_mux_select_o), .rd_word_o(buf_rd_word_i));
    // ==========
    // Shared tasks
    task automatic chk(input logic [656:0] g, input logic [656:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: %s mismatch", $time, m);
        end
    endtask : chk
    // Request holds until the rising edge that sees waitrequest low; data is taken there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 0;
        avs_write_i <= 0;
    endtask : bus
    task automatic rxw(input logic b, input logic e, input logic [7:0] s);
        @(posedge clk_i);
        rx_ctl_valid_i <= 1;
        rx_is_burst_i <= b;
        rx_crc_err_i <= e;
        rx_seq_i <= s;
    endtask : rxw
    task automatic close_out;
        $display("Counts: %0d compared, %0d failed", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // ==========
    // Output watcher takes the oldest note per result
    always @(negedge clk_i) begin
        if (bank_wr_strobe_o !== 4'h0) begin
            if (wq.size() == 0) chk(1, 0, "extra write");
            else chk({buf_wr_word_o, buf_wr_index_o, bank_wr_strobe_o}, wq.pop_front(),
                "write");
        end
        if (out_valid_o === 1'b1) begin
            if (oq.size() == 0) chk(1, 0, "extra replay");
            else chk({out_disc_o, out_data_o}, oq.pop_front(), "replay");
        end
        nd += int'(rx_disc_o === 1'b1);
        nr += int'(rx_rereq_o === 1'b1);
    end
    initial begin
        #2000000;
        fail_count++;
        close_out();
    end
    // ==========
    // Main sequence
    initial begin
        int p;
        logic [671:0] r;
        void'($urandom(32'h82A3));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (3) @(posedge clk_i);
        foreach (RA[i]) begin
            bus(0, RA[i], 0);
            chk(q, RE[i], "reset value");
        end
        bus(1, 4'h4, 32'h203);
        bus(1, 4'hC, 32'h600);
        // Smallest legal multiplier per extension: 4, 8, 16, 32 for 256 to 2048 channels
        for (int i = 0; i < 4; i++) begin
            bus(1, 4'h0, 32'h43 | 32'((i + 2) << 3));
            bus(0, 4'h8, 0);
            chk(q, 32'(SPAN * 8 <= (BURST_WORDS_MAX * MIN_SEQS) << (i + 2)) << 1,
                "depth low");
        end
        bus(1, 4'h0, 32'h73);
        bus(1, 4'h2, 32'hFF);
        bus(0, 4'h0, 0);
        chk(q, 32'h6B, "multiplier");
        bus(0, 4'h2, 0);
        chk(q, 32'h0, "unmapped");
        // Stream crosses into bank 1 and wraps past the span
        for (int k = 0; k < NIN; k++) begin
            for (int i = 0; i < 21; i++) r[i*32+:32] = $urandom;
            hist[k] = r[ENTRY_W-1:0];
            p = k % SPAN;
            wq.push_back({hist[k], 9'(p), 4'(1 << (p / 512))});
            if (k >= NIN - SPAN) oq.push_back({k == NIN - SPAN, hist[k]});
            @(posedge clk_i);
            in_valid_i <= 1;
            in_burst_start_i <= (k % 8 == 0);
            in_data_i <= hist[k];
        end
        @(posedge clk_i);
        in_valid_i <= 0;
        repeat (6) @(posedge clk_i);
        bus(0, 4'h8, 0);
        chk(q, 32'h2032, "status");
        @(negedge clk_i);
        chk(tx_seq_o, 8'h2, "sequence");
        @(posedge clk_i);
        replay_req_valid_i <= 1;
        replay_req_i <= 1;
        @(posedge clk_i);
        replay_req_valid_i <= 0;
        replay_req_i <= 0;
        @(negedge clk_i);
        chk({replay_busy_o, in_ready_o}, 2'b10, "busy");
        for (p = 0; p < 2000 && (p < 5 || replay_busy_o !== 1'b0); p++) @(negedge clk_i);
        repeat (8) @(negedge clk_i);
        chk(oq.size(), 0, "replay count");
        // Receive side is taken to run burst-interleaved, the only mode replay allows
        rxw(1, 0, 8'd157);
        repeat (3) rxw(0, 0, 8'd0);
        rxw(1, 0, 8'd123);
        rxw(0, 1, 8'd0);
        rxw(1, 0, 8'd50);
        rxw(1, 0, 8'd51);
        rxw(1, 0, 8'd200);
        @(posedge clk_i);
        rx_ctl_valid_i <= 0;
        repeat (3) @(negedge clk_i);
        chk(nd, 2, "discontinuity");
        bus(1, 4'hC, 32'h14);
        @(posedge clk_i);
        rx_req_sent_i <= 1;
        @(posedge clk_i);
        rx_req_sent_i <= 0;
        repeat (30) @(negedge clk_i);
        chk(nr, 1, "re-request");
        close_out();
    end
endmodule : tb
`default_nettype wire
